// ### rtl/rhp_port_status.sv
/*
 * Root hub port change-status register with AXI4-Lite access, port power
 * control, command pulses to the port logic and a level interrupt.
 * Assumes current connect, port enable, device-removable and root hub reset
 * completion come from logic on CLK; the low-speed line comes from a pin.
 */
// Overview of operation
// - Hardware clearing of port enable sets change flag.
// - Software-caused enable changes leave flag alone.
// - Write one clears change flags; zero ignored.
// - Connect or disconnect sets connect change flag.
// - Enable, suspend or reset commands while disconnected set connect change flag.
// - Non-removable device: flag only after hub reset while connected, or on a command while disconnected.
// - Bit 9 reads low-speed device attached.
// - Writing one to bit 9 removes port power.
// - Writing one to bit 8 applies port power.
`timescale 1ns/1ps
`default_nettype none

module rhp_port_status
	import rhp_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  ARST_N,
	input  wire logic                  CE,
	input  wire logic [rhp_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                  S_AXI_AWVALID,
	output var  logic                  S_AXI_AWREADY,
	input  wire logic [31:0]           S_AXI_WDATA,
	input  wire logic [3:0]            S_AXI_WSTRB,
	input  wire logic                  S_AXI_WVALID,
	output var  logic                  S_AXI_WREADY,
	output var  logic [1:0]            S_AXI_BRESP,
	output var  logic                  S_AXI_BVALID,
	input  wire logic                  S_AXI_BREADY,
	input  wire logic [rhp_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                  S_AXI_ARVALID,
	output var  logic                  S_AXI_ARREADY,
	output var  logic [31:0]           S_AXI_RDATA,
	output var  logic [1:0]            S_AXI_RRESP,
	output var  logic                  S_AXI_RVALID,
	input  wire logic                  S_AXI_RREADY,
	input  wire logic                  CURRENT_CONNECT,
	input  wire logic                  PORT_ENABLED,
	input  wire logic                  NONREMOVABLE_DEVICE_BIT,
	input  wire logic                  ROOT_HUB_RESET_DONE,
	input  wire logic                  LOW_SPEED_PIN,
	output var  logic                  PORT_POWER_ON,
	output var  rhp_pkg::rhp_cmd_t     PORT_CMD,
	output var  logic                  IRQ
);
	import rhp_pkg::*;

	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              aw_held;
	logic              w_held;
	rhp_bresp_t        b_out;
	logic              low_speed_attached;
	logic              connect_prev;
	logic              enabled_prev;
	logic              sw_disable_pending;
	logic              connect_change_flag;
	logic              port_enable_change_flag;
	logic              port_power_on;
	logic [INT_W-1:0]  int_status;
	logic [INT_W-1:0]  int_enable;
	logic              wr_do;
	logic              wr_status;
	logic              wr_int_clear;
	logic              wr_int_enable;
	logic              wr_mapped;
	logic [31:0]       wmask;
	logic              ar_fire;
	logic              enable_fall;
	logic              ena_chg;
	logic              conn_chg;
	logic              cmd_no_connect;
	logic              sw_disable;
	logic [31:0]       status_word;
	logic [31:0]       next_rdata;
	logic              next_rd_ok;
	logic [INT_W-1:0]  events;

	// The low-speed line is an asynchronous pin and is synchronised first.
	rhp_sync #(
		.WIDTH  (1),
		.STAGES (SYNC_STAGES)
	) u_ls_sync (
		.clk    (CLK),
		.arst_n (ARST_N),
		.ce     (CE),
		.din    (LOW_SPEED_PIN),
		.dout   (low_speed_attached)
	);

	// Write channel: address and data are taken in either order, and the
	// register write happens once both are held and no answer is pending.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
			b_out         <= '0;
		end else if (CE) begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held       <= 1'b1;
				aw_addr       <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held       <= 1'b1;
				w_data       <= S_AXI_WDATA;
				w_strb       <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_do) begin
				b_out.valid <= 1'b1;
				b_out.resp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (b_out.valid && S_AXI_BREADY) begin
				b_out.valid   <= 1'b0;
				aw_held       <= 1'b0;
				w_held        <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	assign S_AXI_BVALID = b_out.valid;
	assign S_AXI_BRESP  = b_out.resp;

	always_comb begin
		wr_do         = aw_held && w_held && !b_out.valid;
		wr_status     = wr_do && (aw_addr == OFS_PORT_STATUS);
		wr_int_clear  = wr_do && (aw_addr == OFS_INT_CLEAR);
		wr_int_enable = wr_do && (aw_addr == OFS_INT_ENABLE);
		wr_mapped     = wr_status || wr_int_clear || wr_int_enable ||
			(aw_addr == OFS_INT_STATUS);
		for (int i = 0; i < 32; i++)
			wmask[i] = w_data[i] && w_strb[i/8];
	end

	// Change detection on the port signals that other logic owns.
	always_comb begin
		enable_fall    = enabled_prev && !PORT_ENABLED;
		ena_chg        = enable_fall && !sw_disable_pending;
		cmd_no_connect = wr_status && !CURRENT_CONNECT &&
			(wmask[BIT_PORT_RESET_CMD] || wmask[BIT_PORT_ENABLE_CMD] ||
			wmask[BIT_PORT_SUSPEND_CMD]);
		conn_chg = (!NONREMOVABLE_DEVICE_BIT &&
			(connect_prev != CURRENT_CONNECT)) ||
			(NONREMOVABLE_DEVICE_BIT && ROOT_HUB_RESET_DONE &&
			CURRENT_CONNECT) ||
			cmd_no_connect;
		sw_disable = wr_status && (wmask[BIT_PORT_DISABLE_CMD] ||
			wmask[BIT_POWER_OFF_CMD]);
		events = '0;
		events[INT_CONNECT_CHANGE] = conn_chg;
		events[INT_ENABLE_CHANGE]  = ena_chg;
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			connect_prev <= 1'b0;
			enabled_prev <= 1'b0;
		end else if (CE) begin
			connect_prev <= CURRENT_CONNECT;
			enabled_prev <= PORT_ENABLED;
		end
	end

	// A fall of the enable that follows a software disable or power-off
	// belongs to software; the mark lasts until the enable is seen low.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			sw_disable_pending <= 1'b0;
		else if (CE) begin
			if (!PORT_ENABLED)
				sw_disable_pending <= 1'b0;
			else if (sw_disable)
				sw_disable_pending <= 1'b1;
		end
	end

	// Setting wins over a write-one clear in the same cycle.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			connect_change_flag     <= RST_FLAG;
			port_enable_change_flag <= RST_FLAG;
		end else if (CE) begin
			connect_change_flag <= conn_chg || (connect_change_flag &&
				!(wr_status && wmask[BIT_CONNECT_CHANGE]));
			port_enable_change_flag <= ena_chg ||
				(port_enable_change_flag &&
				!(wr_status && wmask[BIT_ENABLE_CHANGE]));
		end
	end

	// Power-off wins when both power bits are written as one.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			port_power_on <= RST_POWER;
		else if (CE && wr_status) begin
			if (wmask[BIT_POWER_OFF_CMD])
				port_power_on <= 1'b0;
			else if (wmask[BIT_POWER_ON_CMD])
				port_power_on <= 1'b1;
		end
	end

	assign PORT_POWER_ON = port_power_on;

	// Port commands are one-cycle pulses; ones that need a device are
	// withheld while nothing is connected.
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			PORT_CMD <= '0;
		else if (CE) begin
			PORT_CMD.port_disable_cmd <= wr_status &&
				wmask[BIT_PORT_DISABLE_CMD];
			PORT_CMD.port_enable_cmd  <= wr_status && CURRENT_CONNECT &&
				wmask[BIT_PORT_ENABLE_CMD];
			PORT_CMD.port_suspend_cmd <= wr_status && CURRENT_CONNECT &&
				wmask[BIT_PORT_SUSPEND_CMD];
			PORT_CMD.port_reset_cmd   <= wr_status && CURRENT_CONNECT &&
				wmask[BIT_PORT_RESET_CMD];
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			int_status <= '0;
			int_enable <= RST_INT_ENABLE;
			IRQ        <= 1'b0;
		end else if (CE) begin
			int_status <= events | (int_status &
				~(wr_int_clear ? wmask[INT_W-1:0] : '0));
			if (wr_int_enable)
				int_enable <= wmask[INT_W-1:0];
			IRQ <= |(int_status & int_enable);
		end
	end

	// Read channel answers one cycle after the address is taken.
	always_comb begin
		ar_fire     = S_AXI_ARVALID && S_AXI_ARREADY;
		status_word = '0;
		status_word[BIT_CURRENT_CONNECT] = CURRENT_CONNECT;
		status_word[BIT_PORT_ENABLED]    = PORT_ENABLED;
		status_word[BIT_PORT_POWER_ON]   = port_power_on;
		status_word[BIT_LOW_SPEED]       = low_speed_attached;
		status_word[BIT_CONNECT_CHANGE]  = connect_change_flag;
		status_word[BIT_ENABLE_CHANGE]   = port_enable_change_flag;
		next_rdata = '0;
		next_rd_ok = 1'b1;
		case (S_AXI_ARADDR)
			OFS_PORT_STATUS: next_rdata = status_word;
			OFS_INT_STATUS:  next_rdata[INT_W-1:0] = int_status;
			OFS_INT_CLEAR:   next_rdata = '0;
			OFS_INT_ENABLE:  next_rdata[INT_W-1:0] = int_enable;
			default:         next_rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= '0;
			S_AXI_RRESP   <= RESP_OKAY;
		end else if (CE) begin
			if (ar_fire) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID  <= 1'b1;
				S_AXI_RDATA   <= next_rdata;
				S_AXI_RRESP   <= next_rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID  <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	sequence s_hw_fall;
		CE && enable_fall && !sw_disable_pending;
	endsequence

	chk_hw_loss_set: assert property (s_hw_fall |=> port_enable_change_flag)
		else $error("Hardware enable loss did not set change flag.");
	chk_sw_loss_quiet: assert property (CE && enable_fall &&
		sw_disable_pending && !port_enable_change_flag
		|=> !port_enable_change_flag)
		else $error("Software disable set the enable change flag.");
	chk_flag_clear: assert property (CE && wr_status &&
		wmask[BIT_CONNECT_CHANGE] && !conn_chg |=> !connect_change_flag)
		else $error("Write of one did not clear connect change flag.");
	chk_flag_keep: assert property (CE && wr_status &&
		!wmask[BIT_ENABLE_CHANGE] && port_enable_change_flag
		|=> port_enable_change_flag)
		else $error("Write of zero cleared enable change flag.");
	chk_connect_edge: assert property (CE && !NONREMOVABLE_DEVICE_BIT &&
		$changed(CURRENT_CONNECT) && $past(CE) |=> connect_change_flag)
		else $error("Connect edge did not set connect change flag.");
	chk_cmd_disconn: assert property (CE && cmd_no_connect
		|=> connect_change_flag && PORT_CMD[3:1] == 3'h0)
		else $error("Command while disconnected mishandled.");
	chk_nonrem_hold: assert property (CE && NONREMOVABLE_DEVICE_BIT &&
		!ROOT_HUB_RESET_DONE && !cmd_no_connect && !connect_change_flag
		|=> !connect_change_flag)
		else $error("Connect change set without hub reset.");
	chk_speed_read: assert property (ar_fire && CE &&
		S_AXI_ARADDR == OFS_PORT_STATUS
		|=> S_AXI_RDATA[BIT_LOW_SPEED] == $past(low_speed_attached))
		else $error("Read of bit 9 did not show low-speed state.");
	chk_power_off: assert property (CE && wr_status &&
		wmask[BIT_POWER_OFF_CMD] |=> !PORT_POWER_ON [*1])
		else $error("Power-off write left port powered.");
	chk_power_on: assert property (CE && wr_status &&
		wmask[BIT_POWER_ON_CMD] && !wmask[BIT_POWER_OFF_CMD]
		|=> PORT_POWER_ON)
		else $error("Power-on write did not power port.");
	chk_reserved_zero: assert property (S_AXI_RVALID
		|-> S_AXI_RDATA[RSV_HI:RSV_LO] == '0)
		else $error("Reserved bits read non-zero.");

endmodule // rhp_port_status

`default_nettype wire

// ### rtl/rhp_pkg.sv
/*
 * Shared constants and carrier types for the root hub port change-status
 * block: register offsets, field positions, reset values and bus answers.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package rhp_pkg;

	localparam int ADDR_W = 4;

	localparam logic [ADDR_W-1:0] OFS_PORT_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_INT_STATUS  = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_INT_CLEAR   = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_INT_ENABLE  = 4'hC;

	// Port status word, read side.
	localparam int BIT_CURRENT_CONNECT = 0;
	localparam int BIT_PORT_ENABLED    = 1;
	localparam int BIT_PORT_POWER_ON   = 8;
	localparam int BIT_LOW_SPEED       = 9;
	localparam int BIT_CONNECT_CHANGE  = 16;
	localparam int BIT_ENABLE_CHANGE   = 17;
	localparam int RSV_HI              = 15;
	localparam int RSV_LO              = 10;

	// Port status word, write side.
	localparam int BIT_PORT_DISABLE_CMD = 0;
	localparam int BIT_PORT_ENABLE_CMD  = 1;
	localparam int BIT_PORT_SUSPEND_CMD = 2;
	localparam int BIT_PORT_RESET_CMD   = 4;
	localparam int BIT_POWER_ON_CMD     = 8;
	localparam int BIT_POWER_OFF_CMD    = 9;

	// Interrupt status, clear and enable share this layout.
	localparam int INT_W              = 2;
	localparam int INT_CONNECT_CHANGE = 0;
	localparam int INT_ENABLE_CHANGE  = 1;

	localparam logic             RST_FLAG       = 1'h0;
	localparam logic             RST_POWER      = 1'h0;
	localparam logic [INT_W-1:0] RST_INT_ENABLE = 2'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic port_reset_cmd;
		logic port_suspend_cmd;
		logic port_enable_cmd;
		logic port_disable_cmd;
	} rhp_cmd_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] resp;
	} rhp_bresp_t;

endpackage

// ### rtl/rhp_sync.sv
/*
 * Multi-stage level synchroniser for inputs that arrive from outside the
 * clock domain. Assumes each bit is an independent level.
 */
`timescale 1ns/1ps
`default_nettype none

module rhp_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = 2
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);
	logic [STAGES-1:0][WIDTH-1:0] chain;

	initial begin
		if (WIDTH < 1 || STAGES < 2)
			$error("rhp_sync needs WIDTH >= 1 and STAGES >= 2.");
	end

	// Only the next stage reads each stage, so metastability stays inside.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			chain <= '0;
		else if (ce)
			chain <= {chain[STAGES-2:0], din};
	end

	assign dout = chain[STAGES-1];
endmodule // rhp_sync

`default_nettype wire

// ### testbench/rhp_dev_model.sv
/* Behavioural USB device on the downstream port of the change-status block.
   Assumes the port logic samples connect on the same clock as this model. */
`timescale 1ns/1ps
`default_nettype none
module rhp_dev_model #(
	parameter int SETTLE = 4
) (
	input  wire logic clk,
	input  wire logic attach,
	input  wire logic low_speed,
	output var  logic connect,
	output var  logic ls_pin
);
	int cnt = 0;
	initial connect = 1'b0;
	// A cable settles before it is seen, so attach and detach are slow.
	always @(posedge clk) begin
		if (attach == connect) begin
			cnt <= 0;
		end else if (cnt == SETTLE - 1) begin
			cnt <= 0;
			connect <= attach;
		end else begin
			cnt <= cnt + 1;
		end
	end
	// The speed line is pulled low when no device drives it.
	always_comb ls_pin = connect ? low_speed : 1'b0;
endmodule // rhp_dev_model
`default_nettype wire

// ### testbench/testbench.sv
/* Self-checking bench for the port change-status block over AXI4-Lite.
   Assumes the design package and the device model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rhp_pkg::*;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] CONN_CHG = 32'h10000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic aw = 1'b0;
	logic w = 1'b0;
	logic br = 1'b0;
	logic ar = 1'b0;
	logic rr = 1'b0;
	logic [31:0] wd = '0;
	logic [31:0] rd_d;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic awr, wr_r, bv, arr, rv, pwr, irq, con, ls;
	logic pen = 1'b0;
	logic nrm = 1'b0;
	logic hrst = 1'b0;
	logic att = 1'b0;
	logic lsd = 1'b0;
	rhp_cmd_t cmd;
	int n_mismatch = 0;
	int n_tests = 0;
	always #10 clk = ~clk;
	rhp_port_status rhp_port_status_i (.CLK(clk), .ARST_N(rst_n), .CE(1'b1),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(aw), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w),
		.S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(br), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(ar),
		.S_AXI_ARREADY(arr), .S_AXI_RDATA(rd_d), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .CURRENT_CONNECT(con),
		.PORT_ENABLED(pen), .NONREMOVABLE_DEVICE_BIT(nrm),
		.ROOT_HUB_RESET_DONE(hrst), .LOW_SPEED_PIN(ls),
		.PORT_POWER_ON(pwr), .PORT_CMD(cmd), .IRQ(irq));
	rhp_dev_model rhp_dev_model_i (.clk(clk), .attach(att),
		.low_speed(lsd), .connect(con), .ls_pin(ls));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bwr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wd <= d;
		aw <= 1'b1;
		w <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) aw <= 1'b0;
			if (wr_r) w <= 1'b0;
		end while (bv !== 1'b1);
		br <= 1'b0;
		chk({30'h0, awr, wr_r}, 32'h0);
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic brd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		ar <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) ar <= 1'b0;
		end while (rv !== 1'b1);
		rr <= 1'b0;
		chk({31'h0, arr}, 32'h0);
		chk(rd_d & m, e & m);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	task automatic ri(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		brd(a, e, ALL, RESP_OKAY);
	endtask
	task automatic ps(input logic [31:0] d);
		bwr(OFS_PORT_STATUS, d, RESP_OKAY);
	endtask
	// Software looks at the speed bit only while a device is connected.
	task automatic st(input logic c, e, p, l, cc, ec);
		brd(OFS_PORT_STATUS, {14'h0, ec, cc, 6'h0, l, p, 6'h0, e, c},
			c ? ALL : 32'hFFFFFDFF, RESP_OKAY);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic t_reset;
		chk({30'h0, pwr, irq}, 32'h0);
		st(0, 0, 0, 0, 0, 0);
		ri(OFS_INT_ENABLE, 32'h0);
		brd(4'h2, 32'h0, ALL, RESP_SLVERR);
		bwr(4'h2, ALL, RESP_SLVERR);
		ps(32'h0000FC00);
		st(0, 0, 0, 0, 0, 0);
		$display("test reset finished");
	endtask
	task automatic t_power;
		ps(32'h100);
		chk({31'h0, pwr}, 32'h1);
		ps(32'h0);
		st(0, 0, 1, 0, 0, 0);
		ps(32'h200);
		st(0, 0, 0, 0, 0, 0);
		ps(32'h100);
		ps(32'h300);
		chk({31'h0, pwr}, 32'h0);
		$display("test power finished");
	endtask
	task automatic t_connect;
		bwr(OFS_INT_ENABLE, 32'h1, RESP_OKAY);
		att <= 1'b1;
		cyc(8);
		chk({31'h0, irq}, 32'h1);
		ri(OFS_INT_STATUS, 32'h1);
		st(1, 0, 0, 0, 1, 0);
		bwr(OFS_INT_ENABLE, 32'h0, RESP_OKAY);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		bwr(OFS_INT_ENABLE, 32'h1, RESP_OKAY);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		bwr(OFS_INT_CLEAR, 32'h1, RESP_OKAY);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		ri(OFS_INT_STATUS, 32'h0);
		ri(OFS_INT_CLEAR, 32'h0);
		ps(32'h0);
		st(1, 0, 0, 0, 1, 0);
		ps(CONN_CHG);
		st(1, 0, 0, 0, 0, 0);
		att <= 1'b0;
		cyc(8);
		st(0, 0, 0, 0, 1, 0);
		ps(CONN_CHG);
		bwr(OFS_INT_CLEAR, 32'h3, RESP_OKAY);
		$display("test connect finished");
	endtask
	task automatic t_speed;
		lsd <= 1'b1;
		att <= 1'b1;
		cyc(8);
		st(1, 0, 0, 1, 1, 0);
		att <= 1'b0;
		cyc(8);
		lsd <= 1'b0;
		att <= 1'b1;
		cyc(8);
		st(1, 0, 0, 0, 1, 0);
		att <= 1'b0;
		cyc(8);
		ps(CONN_CHG);
		bwr(OFS_INT_CLEAR, 32'h3, RESP_OKAY);
		$display("test speed finished");
	endtask
	task automatic t_enable;
		pen <= 1'b1;
		cyc(2);
		st(0, 1, 0, 0, 0, 0);
		pen <= 1'b0;
		cyc(2);
		st(0, 0, 0, 0, 0, 1);
		ri(OFS_INT_STATUS, 32'h2);
		ps(32'h0);
		st(0, 0, 0, 0, 0, 1);
		ps(32'h20000);
		st(0, 0, 0, 0, 0, 0);
		for (int i = 0; i < 2; i++) begin
			pen <= 1'b1;
			cyc(2);
			ps(i == 0 ? 32'h1 : 32'h200);
			pen <= 1'b0;
			cyc(2);
			st(0, 0, 0, 0, 0, 0);
		end
		bwr(OFS_INT_CLEAR, 32'h3, RESP_OKAY);
		$display("test enable finished");
	endtask
	task automatic t_cmd;
		int b[3];
		b = '{BIT_PORT_ENABLE_CMD, BIT_PORT_SUSPEND_CMD, BIT_PORT_RESET_CMD};
		foreach (b[i]) begin
			ps(32'h1 << b[i]);
			chk({28'h0, cmd}, 32'h0);
			st(0, 0, 0, 0, 1, 0);
			ps(CONN_CHG);
		end
		att <= 1'b1;
		cyc(8);
		ps(CONN_CHG);
		ps(32'h2);
		chk({28'h0, cmd}, 32'h2);
		st(1, 0, 0, 0, 0, 0);
		ps(32'h4);
		chk({28'h0, cmd}, 32'h4);
		ps(32'h10);
		chk({28'h0, cmd}, 32'h8);
		ps(32'h1);
		chk({28'h0, cmd}, 32'h1);
		$display("test command finished");
	endtask
	task automatic t_nonrem;
		att <= 1'b0;
		cyc(8);
		ps(CONN_CHG);
		nrm <= 1'b1;
		att <= 1'b1;
		cyc(8);
		st(1, 0, 0, 0, 0, 0);
		hrst <= 1'b1;
		@(posedge clk);
		hrst <= 1'b0;
		cyc(2);
		st(1, 0, 0, 0, 1, 0);
		nrm <= 1'b0;
		bwr(OFS_INT_CLEAR, 32'h3, RESP_OKAY);
		$display("test nonremovable finished");
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_power();
		t_connect();
		t_speed();
		t_enable();
		t_cmd();
		t_nonrem();
		results();
	end
endmodule // testbench
`default_nettype wire
